/* hw/pkh_pkg.sv */
/*
  Constants and types shared by the packet handler register bank and its
  testbench: register indices, field positions, reset values and bus codes.
  Assumes an AXI4-Lite bus with 32-bit data, one register per aligned word.
*/
package pkh_pkg;

  // register indices; the byte address is four times the index
  localparam logic [5:0] IDX_SUPPLY_CFG  = 6'h05;
  localparam logic [5:0] IDX_SUPPLY_STAT = 6'h06;
  localparam logic [5:0] IDX_CODING      = 6'h1C;
  localparam logic [5:0] IDX_NODE        = 6'h1D;
  localparam logic [5:0] IDX_FORMAT      = 6'h1E;
  localparam logic [5:0] IDX_PAGE        = 6'h1F;

  // reset values
  localparam logic [7:0] RST_SUPPLY_CFG  = 8'hB1;
  localparam logic [7:0] RST_SUPPLY_STAT = 8'h96;
  localparam logic [7:0] RST_CODING      = 8'h00;
  localparam logic [7:0] RST_NODE        = 8'h00;
  localparam logic [7:0] RST_FORMAT      = 8'h40;
  localparam logic [7:0] RST_PAGE        = 8'h00;

  // coding_and_length fields
  localparam int B_MANCHESTER = 7;
  localparam int B_LEN_HI     = 6;
  // packet_format_control fields
  localparam int B_LEN_MODE   = 7;
  localparam int B_PRE_HI     = 6;
  localparam int B_PRE_LO     = 5;
  localparam int B_WHITEN     = 4;
  localparam int B_CHECK_EN   = 3;
  localparam int B_FILT_HI    = 2;
  localparam int B_FILT_LO    = 1;
  localparam int B_CHECK_OK   = 0;
  // fifo_and_bank_control fields
  localparam int B_AUTO_FLUSH = 7;
  localparam int B_FIFO_DIR   = 6;
  localparam int B_PAGE_HI    = 1;
  localparam logic [7:0] PAGE_WMASK = 8'hC3;
  // supply monitor fields
  localparam int B_SUP_EN     = 3;
  localparam int B_THR_HI     = 2;
  localparam int B_SUP_OK     = 7;
  localparam int B_SUP_ROUTE  = 6;
  localparam logic [7:0] STAT_WMASK = 8'h7F;

  localparam logic [1:0] PAGE0 = 2'h0;
  localparam logic [1:0] PAGE1 = 2'h1;

  localparam logic [1:0] FILT_NONE = 2'h0;
  localparam logic [1:0] FILT_ZERO = 2'h2;
  localparam logic [1:0] FILT_BOTH = 2'h3;
  localparam logic [7:0] ADDR_ZERO  = 8'h00;
  localparam logic [7:0] ADDR_BCAST = 8'hFF;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    REG_NONE, REG_SUPPLY_CFG, REG_SUPPLY_STAT, REG_CODING, REG_NODE, REG_FORMAT, REG_PAGE
  } pkh_reg_t;

  // configuration that steers the framer, fifo and supply monitor
  typedef struct packed {
    logic       manchester_enable;
    logic [6:0] payload_length_field;
    logic       length_mode_select;
    logic [2:0] preamble_bytes;
    logic       whitening_enable;
    logic       check_enable;
    logic [1:0] address_filter_select;
    logic [7:0] node_address_field;
    logic       auto_flush_on_check_fail;
    logic       fifo_direction_select;
    logic [1:0] map_bank_select;
    logic       supply_monitor_enable;
    logic [2:0] supply_threshold_select;
  } pkh_cfg_t;

  // events reported by the framer on the bank's own clock
  typedef struct packed {
    logic       rx_active;
    logic       check_done;
    logic       check_pass;
    logic       addr_valid;
    logic [7:0] addr;
    logic       len_valid;
    logic [7:0] len;
  } pkh_rx_t;

endpackage

/* hw/pkh_sync.sv */
/*
  Three-stage synchroniser with agreement filter for one asynchronous level.
  Assumes the input is quasi-static compared with the clock.
*/
`timescale 1ns/10ps
`default_nettype none
module pkh_sync #(
  parameter logic RESET_VALUE = 1'b1
) (
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // level
  input  wire logic din,
  output logic      dout
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
  } pkh_sync_t;

  pkh_sync_t q;
  pkh_sync_t next_q;

  always_comb begin
    next_q    = q;
    next_q.s1 = din;
    next_q.s2 = q.s1;
    next_q.s3 = q.s2;
    // first stage feeds only the second; the filter looks at stages two and three
    if (q.s2 == q.s3) begin
      next_q.level = q.s3;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '{RESET_VALUE, RESET_VALUE, RESET_VALUE, RESET_VALUE};
    end else begin
      q <= next_q;
    end
  end

  assign dout = q.level;

endmodule
`default_nettype wire

/* hw/pkh_bank.sv */
/*
  Packet handler configuration and status register bank with a two-page map,
  reached over AXI4-Lite. Drives the framer, fifo and supply monitor settings
  and observes check results, received address and length, and the battery
  comparator. Assumes framer events are on aclk; the comparator is asynchronous.
*/
`timescale 1ns/10ps
`default_nettype none
module pkh_bank #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // axi4-lite write address and data
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // axi4-lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi4-lite read
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // framer side
  input  wire pkh_pkg::pkh_rx_t  rx,
  output pkh_pkg::pkh_cfg_t      cfg,
  output logic                   fifo_flush,
  output logic                   addr_accept,
  output logic                   len_reject,
  // supply monitor
  input  wire logic              supply_above,
  output logic                   supply_alarm
);

  typedef struct packed {
    logic              awready;
    logic              wready;
    logic              aw_held;
    pkh_pkg::pkh_reg_t aw_reg;
    logic              w_held;
    logic [7:0]        w_byte;
    logic              w_lane;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [1:0]        rresp;
    logic [7:0]        rdata;
    logic [7:0]        coding;
    logic [7:0]        node;
    logic [7:0]        format;
    logic [7:0]        page_ctl;
    logic [7:0]        sup_cfg;
    logic [7:0]        sup_stat;
    pkh_pkg::pkh_cfg_t cfg;
    logic              flush;
    logic              accept;
    logic              reject;
    logic              alarm;
  } pkh_state_t;

  pkh_state_t q;
  pkh_state_t next_q;
  logic       supply_level;
  logic       wr_go;

  pkh_sync #(
    .RESET_VALUE (pkh_pkg::RST_SUPPLY_STAT[pkh_pkg::B_SUP_OK])
  ) u_supply_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     (supply_above),
    .dout    (supply_level)
  );

  function automatic pkh_pkg::pkh_reg_t decode(input logic [ADDR_W-1:0] addr, input logic [1:0] page);
    logic [5:0] idx;
    idx = addr[7:2];
    decode = pkh_pkg::REG_NONE;
    if (addr[1:0] == 2'h0 && (ADDR_W <= 8 || addr[ADDR_W-1:0] >> 8 == '0)) begin
      if (idx == pkh_pkg::IDX_PAGE) begin
        decode = pkh_pkg::REG_PAGE;
      end else if (page == pkh_pkg::PAGE0) begin
        case (idx)
          pkh_pkg::IDX_CODING: decode = pkh_pkg::REG_CODING;
          pkh_pkg::IDX_NODE:   decode = pkh_pkg::REG_NODE;
          pkh_pkg::IDX_FORMAT: decode = pkh_pkg::REG_FORMAT;
          default:             decode = pkh_pkg::REG_NONE;
        endcase
      end else if (page == pkh_pkg::PAGE1) begin
        case (idx)
          pkh_pkg::IDX_SUPPLY_CFG:  decode = pkh_pkg::REG_SUPPLY_CFG;
          pkh_pkg::IDX_SUPPLY_STAT: decode = pkh_pkg::REG_SUPPLY_STAT;
          default:                  decode = pkh_pkg::REG_NONE;
        endcase
      end
    end
  endfunction

  always_comb begin
    logic              aw_have;
    logic              w_have;
    pkh_pkg::pkh_reg_t sel;
    pkh_pkg::pkh_reg_t rsel;
    logic              filt_hit;
    next_q   = q;
    aw_have  = q.aw_held;
    w_have   = q.w_held;
    sel      = q.aw_reg;
    rsel     = pkh_pkg::REG_NONE;
    filt_hit = 1'b0;
    wr_go    = 1'b0;
    next_q.flush = 1'b0;

    // write channel: address and data taken in either order
    if (s_axi_awvalid && q.awready) begin
      aw_have = 1'b1;
      sel     = decode(s_axi_awaddr, q.page_ctl[pkh_pkg::B_PAGE_HI:0]);
    end
    if (s_axi_wvalid && q.wready) begin
      w_have        = 1'b1;
      next_q.w_byte = s_axi_wdata[7:0];
      next_q.w_lane = s_axi_wstrb[0];
    end
    next_q.aw_held = aw_have;
    next_q.aw_reg  = sel;
    next_q.w_held  = w_have;
    if (q.bvalid && s_axi_bready) begin
      next_q.bvalid = 1'b0;
    end
    if (aw_have && w_have && !q.bvalid) begin
      wr_go          = 1'b1;
      next_q.aw_held = 1'b0;
      next_q.w_held  = 1'b0;
      next_q.bvalid  = 1'b1;
      next_q.bresp   = (sel == pkh_pkg::REG_NONE) ? pkh_pkg::RESP_SLVERR : pkh_pkg::RESP_OKAY;
      if (next_q.w_lane) begin
        case (sel)
          pkh_pkg::REG_CODING:     next_q.coding  = next_q.w_byte;
          pkh_pkg::REG_NODE:       next_q.node    = next_q.w_byte;
          pkh_pkg::REG_FORMAT: begin
            next_q.format[7:1] = next_q.w_byte[7:1];
            if (next_q.w_byte[pkh_pkg::B_CHECK_OK]) begin
              next_q.format[pkh_pkg::B_CHECK_OK] = 1'b0;
            end
          end
          pkh_pkg::REG_PAGE:       next_q.page_ctl = next_q.w_byte & pkh_pkg::PAGE_WMASK;
          pkh_pkg::REG_SUPPLY_CFG: next_q.sup_cfg  = next_q.w_byte;
          pkh_pkg::REG_SUPPLY_STAT: begin
            next_q.sup_stat = (q.sup_stat & ~pkh_pkg::STAT_WMASK) | (next_q.w_byte & pkh_pkg::STAT_WMASK);
          end
          default: ;
        endcase
      end
    end
    next_q.awready = !next_q.aw_held && !next_q.bvalid;
    next_q.wready  = !next_q.w_held && !next_q.bvalid;

    // read channel: one read at a time, data registered at acceptance
    if (q.rvalid && s_axi_rready) begin
      next_q.rvalid = 1'b0;
    end
    if (s_axi_arvalid && q.arready) begin
      rsel          = decode(s_axi_araddr, q.page_ctl[pkh_pkg::B_PAGE_HI:0]);
      next_q.rvalid = 1'b1;
      next_q.rresp  = (rsel == pkh_pkg::REG_NONE) ? pkh_pkg::RESP_SLVERR : pkh_pkg::RESP_OKAY;
      case (rsel)
        pkh_pkg::REG_CODING:      next_q.rdata = q.coding;
        pkh_pkg::REG_NODE:        next_q.rdata = q.node;
        pkh_pkg::REG_FORMAT:      next_q.rdata = q.format;
        pkh_pkg::REG_PAGE:        next_q.rdata = q.page_ctl;
        pkh_pkg::REG_SUPPLY_CFG:  next_q.rdata = q.sup_cfg;
        pkh_pkg::REG_SUPPLY_STAT: next_q.rdata = q.sup_stat;
        default:                  next_q.rdata = 8'h00;
      endcase
    end
    next_q.arready = !next_q.rvalid;

    // hardware result wins over a same-cycle clear
    if (rx.check_done && q.format[pkh_pkg::B_CHECK_EN]) begin
      next_q.format[pkh_pkg::B_CHECK_OK] = rx.check_pass;
    end

    if (rx.check_done && !rx.check_pass && rx.rx_active && q.format[pkh_pkg::B_CHECK_EN]
        && !q.page_ctl[pkh_pkg::B_AUTO_FLUSH]) begin
      next_q.flush = 1'b1;
    end

    if (rx.addr_valid) begin
      case (q.format[pkh_pkg::B_FILT_HI:pkh_pkg::B_FILT_LO])
        pkh_pkg::FILT_NONE: filt_hit = 1'b1;
        pkh_pkg::FILT_ZERO: filt_hit = (rx.addr == q.node) || (rx.addr == pkh_pkg::ADDR_ZERO);
        pkh_pkg::FILT_BOTH: filt_hit = (rx.addr == q.node) || (rx.addr == pkh_pkg::ADDR_ZERO)
                                       || (rx.addr == pkh_pkg::ADDR_BCAST);
        default:            filt_hit = (rx.addr == q.node);
      endcase
      next_q.accept = filt_hit;
    end

    // length byte above the cap is refused in variable mode only
    if (rx.len_valid) begin
      next_q.reject = q.format[pkh_pkg::B_LEN_MODE] && (rx.len > {1'b0, q.coding[pkh_pkg::B_LEN_HI:0]});
    end

    // comparator sampled only while detection is on
    if (q.sup_cfg[pkh_pkg::B_SUP_EN]) begin
      next_q.sup_stat[pkh_pkg::B_SUP_OK] = supply_level;
    end
    next_q.alarm = next_q.sup_stat[pkh_pkg::B_SUP_ROUTE] && next_q.sup_cfg[pkh_pkg::B_SUP_EN]
                   && !next_q.sup_stat[pkh_pkg::B_SUP_OK];

    next_q.cfg.manchester_enable        = next_q.coding[pkh_pkg::B_MANCHESTER];
    next_q.cfg.payload_length_field     = next_q.coding[pkh_pkg::B_LEN_HI:0];
    next_q.cfg.length_mode_select       = next_q.format[pkh_pkg::B_LEN_MODE];
    next_q.cfg.preamble_bytes           = {1'b0, next_q.format[pkh_pkg::B_PRE_HI:pkh_pkg::B_PRE_LO]} + 3'h1;
    next_q.cfg.whitening_enable         = next_q.format[pkh_pkg::B_WHITEN];
    next_q.cfg.check_enable             = next_q.format[pkh_pkg::B_CHECK_EN];
    next_q.cfg.address_filter_select    = next_q.format[pkh_pkg::B_FILT_HI:pkh_pkg::B_FILT_LO];
    next_q.cfg.node_address_field       = next_q.node;
    next_q.cfg.auto_flush_on_check_fail = next_q.page_ctl[pkh_pkg::B_AUTO_FLUSH];
    next_q.cfg.fifo_direction_select    = next_q.page_ctl[pkh_pkg::B_FIFO_DIR];
    next_q.cfg.map_bank_select          = next_q.page_ctl[pkh_pkg::B_PAGE_HI:0];
    next_q.cfg.supply_monitor_enable    = next_q.sup_cfg[pkh_pkg::B_SUP_EN];
    next_q.cfg.supply_threshold_select  = next_q.sup_cfg[pkh_pkg::B_THR_HI:0];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q                 <= '0;
      q.awready         <= 1'b1;
      q.wready          <= 1'b1;
      q.arready         <= 1'b1;
      q.coding          <= pkh_pkg::RST_CODING;
      q.node            <= pkh_pkg::RST_NODE;
      q.format          <= pkh_pkg::RST_FORMAT;
      q.page_ctl        <= pkh_pkg::RST_PAGE;
      q.sup_cfg         <= pkh_pkg::RST_SUPPLY_CFG;
      q.sup_stat        <= pkh_pkg::RST_SUPPLY_STAT;
      q.cfg.length_mode_select      <= pkh_pkg::RST_FORMAT[pkh_pkg::B_LEN_MODE];
      q.cfg.preamble_bytes          <= {1'b0, pkh_pkg::RST_FORMAT[pkh_pkg::B_PRE_HI:pkh_pkg::B_PRE_LO]} + 3'h1;
      q.cfg.supply_monitor_enable   <= pkh_pkg::RST_SUPPLY_CFG[pkh_pkg::B_SUP_EN];
      q.cfg.supply_threshold_select <= pkh_pkg::RST_SUPPLY_CFG[pkh_pkg::B_THR_HI:0];
    end else begin
      q <= next_q;
    end
  end

  assign s_axi_awready = q.awready;
  assign s_axi_wready  = q.wready;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid  = q.rvalid;
  assign s_axi_rresp   = q.rresp;
  assign s_axi_rdata   = {24'h000000, q.rdata};
  assign cfg           = q.cfg;
  assign fifo_flush    = q.flush;
  assign addr_accept   = q.accept;
  assign len_reject    = q.reject;
  assign supply_alarm  = q.alarm;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  flag_pass_a: assert property (rx.check_done && rx.check_pass && cfg.check_enable |=> q.format[0])
    else $error("check flag not set after pass");
  flag_fail_a: assert property (rx.check_done && !rx.check_pass && cfg.check_enable |=> !q.format[0])
    else $error("check flag not zero after fail");
  flag_clear_a: assert property (wr_go && next_q.aw_reg == pkh_pkg::REG_FORMAT && next_q.w_lane
      && next_q.w_byte[0] && !rx.check_done |=> !q.format[0])
    else $error("write one did not clear check flag");
  flush_fire_a: assert property (rx.check_done && !rx.check_pass && rx.rx_active && cfg.check_enable
      && !cfg.auto_flush_on_check_fail |=> fifo_flush ##1 (!fifo_flush || $past(rx.check_done)))
    else $error("fifo flush pulse wrong");
  flush_kept_a: assert property (fifo_flush |-> !$past(cfg.auto_flush_on_check_fail))
    else $error("fifo flushed while kept");
  preamble_count_a: assert property (cfg.preamble_bytes == {1'b0, q.format[6:5]} + 3'h1)
    else $error("preamble count mismatch");
  page_write_a: assert property (wr_go && next_q.aw_reg == pkh_pkg::REG_PAGE && next_q.w_lane
      |=> cfg.map_bank_select == $past(next_q.w_byte[1:0]))
    else $error("page select not updated");
  filter_all_a: assert property (rx.addr_valid && cfg.address_filter_select == 2'h0 |=> addr_accept)
    else $error("open filter refused packet");
  alarm_pin_a: assert property (supply_alarm == (q.sup_stat[6] && cfg.supply_monitor_enable
      && !q.sup_stat[7]))
    else $error("alarm pin wrong");
  len_cap_a: assert property (rx.len_valid && !cfg.length_mode_select |=> !len_reject)
    else $error("fixed mode refused length");
  len_over_a: assert property (rx.len_valid && cfg.length_mode_select
      && rx.len > {1'b0, cfg.payload_length_field} |=> len_reject)
    else $error("length above cap not refused");
  flag_frozen_a: assert property (!cfg.supply_monitor_enable |=> $stable(q.sup_stat[pkh_pkg::B_SUP_OK]))
    else $error("supply ok flag moved while off");
  unmapped_err_a: assert property (wr_go && next_q.aw_reg == pkh_pkg::REG_NONE
      |=> s_axi_bresp == pkh_pkg::RESP_SLVERR)
    else $error("unmapped write not refused");

endmodule
`default_nettype wire

/* test/testbench.sv */
/*
  Self-checking bench for the packet handler register bank: register access
  over AXI4-Lite, reset values, paging, check flag, filters and supply monitor.
  Assumes the bank answers every request well within the watchdog span.
*/
`timescale 1ns/10ps
`default_nettype none
module testbench;
  // clock and reset
  logic                aclk;
  logic                aresetn;
  // register bus
  logic [7:0]          s_axi_awaddr;
  logic                s_axi_awvalid;
  logic                s_axi_awready;
  logic [31:0]         s_axi_wdata;
  logic [3:0]          s_axi_wstrb;
  logic                s_axi_wvalid;
  logic                s_axi_wready;
  logic [1:0]          s_axi_bresp;
  logic                s_axi_bvalid;
  logic                s_axi_bready;
  logic [7:0]          s_axi_araddr;
  logic                s_axi_arvalid;
  logic                s_axi_arready;
  logic [31:0]         s_axi_rdata;
  logic [1:0]          s_axi_rresp;
  logic                s_axi_rvalid;
  logic                s_axi_rready;
  // framer and supply side
  pkh_pkg::pkh_rx_t    rx;
  pkh_pkg::pkh_cfg_t   cfg;
  logic                fifo_flush;
  logic                addr_accept;
  logic                len_reject;
  logic                supply_above;
  logic                supply_alarm;
  int                  miscompares;
  int                  checked;
  logic [1:0]          resp;
  logic [7:0]          av [4];

  pkh_bank i_pkh_bank (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .rx(rx), .cfg(cfg),
    .fifo_flush(fifo_flush), .addr_accept(addr_accept), .len_reject(len_reject),
    .supply_above(supply_above), .supply_alarm(supply_alarm));

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // bready and rready stay high, so the answer is taken at the edge it is seen
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done  = 1'b0;
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= {24'h000000, d};
    s_axi_wvalid  <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        break;
      end
      if (!aw_done && s_axi_awready) begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_done && s_axi_wready) begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        break;
      end
      if (s_axi_arready) begin
        s_axi_arvalid <= 1'b0;
      end
    end
  endtask

  task automatic wok(input logic [7:0] a, input logic [7:0] d);
    logic [1:0] r;
    wr(a, d, r);
    chk({30'h0, r}, {30'h0, pkh_pkg::RESP_OKAY});
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(d, {24'h000000, e});
    chk({30'h0, r}, {30'h0, er});
  endtask

  // one framer event: k 0 check, 1 address, 2 length; returns at the edge the result is seen
  task automatic ev(input int k, input logic [7:0] v, input logic p);
    rx.rx_active <= 1'b1;
    rx.check_pass <= p;
    rx.addr <= v;
    rx.len <= v;
    rx.check_done <= (k == 0);
    rx.addr_valid <= (k == 1);
    rx.len_valid <= (k == 2);
    @(posedge aclk);
    rx <= '0;
    @(posedge aclk);
  endtask

  initial begin
    #800000;
    miscompares++;
    tally_and_finish();
  end

  initial begin
    miscompares = 0;
    checked = 0;
    av = '{8'h5A, 8'h00, 8'hFF, 8'h33};
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_araddr, s_axi_arvalid} = '0;
    s_axi_wstrb = 4'hF;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    rx = '0;
    supply_above = 1'b1;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rchk(8'h70, 8'h00, pkh_pkg::RESP_OKAY);
    rchk(8'h74, 8'h00, pkh_pkg::RESP_OKAY);
    rchk(8'h78, 8'h40, pkh_pkg::RESP_OKAY);
    rchk(8'h7C, 8'h00, pkh_pkg::RESP_OKAY);
    chk({29'h0, cfg.preamble_bytes}, 32'h3);
    rchk(8'h00, 8'h00, pkh_pkg::RESP_SLVERR);
    wr(8'h40, 8'h55, resp);
    chk({30'h0, resp}, {30'h0, pkh_pkg::RESP_SLVERR});
    // preamble codes with variable mode, whitening and check on
    for (int f = 0; f < 4; f++) begin
      wok(8'h78, {1'b1, f[1:0], 5'b11000});
      rchk(8'h78, {1'b1, f[1:0], 5'b11000}, pkh_pkg::RESP_OKAY);
      chk({29'h0, cfg.preamble_bytes}, f + 1);
      chk({29'h0, cfg.length_mode_select, cfg.whitening_enable, cfg.check_enable}, 32'h7);
    end
    wok(8'h70, 8'h85);
    chk({24'h0, cfg.manchester_enable, cfg.payload_length_field}, 32'h85);
    ev(2, 8'h06, 1'b0);
    chk({31'h0, len_reject}, 32'h1);
    ev(2, 8'h05, 1'b0);
    chk({31'h0, len_reject}, 32'h0);
    wok(8'h78, 8'h00);
    ev(2, 8'h06, 1'b0);
    chk({31'h0, len_reject}, 32'h0);
    wok(8'h70, 8'h05);
    chk({31'h0, cfg.manchester_enable}, 32'h0);
    // every filter code against node, zero, broadcast and a stranger
    wok(8'h74, 8'h5A);
    chk({24'h0, cfg.node_address_field}, 32'h5A);
    s_axi_wstrb <= 4'h0;
    wok(8'h74, 8'hA5);
    s_axi_wstrb <= 4'hF;
    chk({24'h0, cfg.node_address_field}, 32'h5A);
    for (int c = 0; c < 4; c++) begin
      wok(8'h78, {5'b00000, c[1:0], 1'b0});
      chk({30'h0, cfg.address_filter_select}, c);
      for (int i = 0; i < 4; i++) begin
        ev(1, av[i], 1'b0);
        chk({31'h0, addr_accept}, {31'h0, c == 0 || i == 0 || (c >= 2 && i == 1) || (c == 3 && i == 2)});
      end
    end
    ev(0, 8'h00, 1'b1);
    rchk(8'h78, 8'h06, pkh_pkg::RESP_OKAY);
    // check flag: set, write-zero, write-one clear, failure and flush
    wok(8'h78, 8'h08);
    ev(0, 8'h00, 1'b1);
    chk({31'h0, fifo_flush}, 32'h0);
    rchk(8'h78, 8'h09, pkh_pkg::RESP_OKAY);
    wok(8'h78, 8'h08);
    rchk(8'h78, 8'h09, pkh_pkg::RESP_OKAY);
    wok(8'h78, 8'h09);
    rchk(8'h78, 8'h08, pkh_pkg::RESP_OKAY);
    ev(0, 8'h00, 1'b1);
    ev(0, 8'h00, 1'b0);
    chk({31'h0, fifo_flush}, 32'h1);
    @(posedge aclk);
    chk({31'h0, fifo_flush}, 32'h0);
    rchk(8'h78, 8'h08, pkh_pkg::RESP_OKAY);
    wok(8'h7C, 8'hFC);
    rchk(8'h7C, 8'hC0, pkh_pkg::RESP_OKAY);
    chk({30'h0, cfg.auto_flush_on_check_fail, cfg.fifo_direction_select}, 32'h3);
    ev(0, 8'h00, 1'b0);
    chk({31'h0, fifo_flush}, 32'h0);
    // paging: page 2 shows only the page register
    wok(8'h7C, 8'h02);
    rchk(8'h14, 8'h00, pkh_pkg::RESP_SLVERR);
    rchk(8'h7C, 8'h02, pkh_pkg::RESP_OKAY);
    wok(8'h7C, 8'h01);
    chk({30'h0, cfg.map_bank_select}, {30'h0, pkh_pkg::PAGE1});
    rchk(8'h70, 8'h00, pkh_pkg::RESP_SLVERR);
    rchk(8'h14, 8'hB1, pkh_pkg::RESP_OKAY);
    rchk(8'h18, 8'h96, pkh_pkg::RESP_OKAY);
    for (int t = 0; t < 8; t++) begin
      wok(8'h14, {5'b10110, t[2:0]});
      chk({29'h0, cfg.supply_threshold_select}, t);
    end
    // flag is frozen while the monitor is off and ignores writes
    supply_above <= 1'b0;
    wok(8'h18, 8'hD6);
    repeat (8) @(posedge aclk);
    rchk(8'h18, 8'hD6, pkh_pkg::RESP_OKAY);
    chk({31'h0, supply_alarm}, 32'h0);
    wok(8'h14, 8'hB9);
    chk({31'h0, cfg.supply_monitor_enable}, 32'h1);
    repeat (8) @(posedge aclk);
    rchk(8'h18, 8'h56, pkh_pkg::RESP_OKAY);
    chk({31'h0, supply_alarm}, 32'h1);
    supply_above <= 1'b1;
    repeat (8) @(posedge aclk);
    rchk(8'h18, 8'hD6, pkh_pkg::RESP_OKAY);
    chk({31'h0, supply_alarm}, 32'h0);
    wok(8'h18, 8'h16);
    supply_above <= 1'b0;
    repeat (8) @(posedge aclk);
    rchk(8'h18, 8'h16, pkh_pkg::RESP_OKAY);
    chk({31'h0, supply_alarm}, 32'h0);
    wok(8'h7C, 8'h00);
    rchk(8'h74, 8'h5A, pkh_pkg::RESP_OKAY);
    tally_and_finish();
  end
endmodule
`default_nettype wire
